/* design/mp_seq_regs.svh */
`ifndef MP_SEQ_REGS_SVH
`define MP_SEQ_REGS_SVH
// Opcodes
`define OP_PROG_SETUP    8'h80
`define OP_PROG_SETUP_ALT 8'h81
`define OP_COL_CHANGE    8'h85
`define OP_PROG_QUEUE    8'h11
`define OP_PROG_FINAL    8'h10
`define OP_PROG_CACHE    8'h15
`define OP_ERASE_SETUP   8'h60
`define OP_ERASE_FINAL   8'hD0
`define OP_ERASE_QUEUE   8'hD1
`define OP_STATUS        8'h70
`define OP_STATUS_SEL    8'h78
`define OP_RESET         8'hFF
// Address cycle counts
`define PROG_ADDR_CYCLES  3'h5
`define COL_ADDR_CYCLES   3'h2
`define ERASE_ADDR_CYCLES 3'h3
// Value a cleared cache byte takes
`define ERASED_BYTE 8'hFF
// Row layout: low page bits ignored for erase
`define PAGE_BITS 8
// Controller register offsets
`define REG_CMD    4'h0
`define REG_ADDR   4'h1
`define REG_STATUS 4'h2
`define REG_FAIL   4'h3
// Busy times in ns and derived cycles at 100 MHz
`define CLK_PERIOD_NS      10
`define QUEUE_BUSY_NS      500
`define CACHE_BUSY_NS      2000
`define QUEUE_BUSY_CYC     (`QUEUE_BUSY_NS / `CLK_PERIOD_NS)
`define CACHE_BUSY_CYC     (`CACHE_BUSY_NS / `CLK_PERIOD_NS)
`define PROG_TIME_CYC      1000
`define ERASE_TIME_CYC     2000
`endif

/* design/mp_seq_pkg.sv */
package mp_seq_pkg;
   // Kind of cycle on the command bus
   typedef enum logic [1:0] {CYC_CMD, CYC_ADDR, CYC_DATA} cyc_kind_e;
endpackage : mp_seq_pkg

/* design/mp_seq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mp_seq_if;
   logic       cyc_valid;   // One cycle on the bus
   logic [1:0] cyc_kind;    // Command, address or data
   logic [7:0] cyc_byte;    // Cycle payload
   logic       ready_busy_n;// Die ready when high
   logic       status_valid;// Status byte answer valid
   logic [7:0] status_byte; // Status byte
   modport die  (input cyc_valid, cyc_kind, cyc_byte,
                 output ready_busy_n, status_valid, status_byte);
   modport ctrl (output cyc_valid, cyc_kind, cyc_byte,
                 input ready_busy_n, status_valid, status_byte);
endinterface : mp_seq_if
`default_nettype wire

/* design/mp_seq_die.sv */
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mp_seq_regs.svh"
// =====================================================================
// Overview of operation
// - 80h, five address cycles, data, 11h queues plane
// - 80h clears caches unless after 11h
// - Data at column; 85h changes column during data input only
// - After 11h both flags low for queue time
// - Program setup accepted only while die ready
// - Host polls ready pin or status 70h/78h
// - After ready, queue more or end 10h/15h
// - 10h programs all queued planes, page time
// - Per-plane fail flags after program completes
// - 15h waits array, copies, starts within cache time; here a 15h is ignored while the array is busy
// - Per-plane prior cache fail after cache time plus program time
// - 81h works as alternate setup opcode
// - Erase accepted only when both flags ready
// - 60h, three rows, D0h; page bits ignored
// - Erase busy erase time, then fail flag
// - Multi-die hosts read status with 78h only
// - 60h rows D1h queues block, queue busy
// - After ready, queue more; 60h-D0h erases all
// - Final D0h erases every queued plane block
// - 60h row 60h row D0h means D1h, D0h
// - Cache program: die ready, array busy
module mp_seq_die #(
   parameter int PLANES    = 2,
   parameter int PAGE_BYTES= 256,
   parameter int PROG_CYC  = `PROG_TIME_CYC,
   parameter int ERASE_CYC = `ERASE_TIME_CYC,
   parameter logic [PLANES-1:0] FAIL_INJECT = '0
) (
   input  wire logic       i_clk,        // 100 MHz clock
   input  wire logic       i_reset,      // Synchronous reset
   mp_seq_if.die           bus,          // Command/address/data link
   output logic            o_die_ready,  // die_ready_flag
   output logic            o_array_ready,// array_ready_flag
   output logic [PLANES-1:0] o_fail,     // op_fail_flag per plane
   output logic [PLANES-1:0] o_cache_fail// prior_cache_fail_flag per plane
);
   typedef enum logic [2:0] {S_IDLE, S_PADDR, S_PDATA, S_EADDR, S_EWAIT} seq_e;
   localparam int PB = $clog2(PLANES);
   localparam int CW = $clog2(PAGE_BYTES);

   seq_e                  st_q;
   logic [2:0]            acnt_q;
   logic [39:0]           addr_q;
   logic [CW-1:0]         col_q;
   logic                  after_queue_q;
   logic [PLANES-1:0]     queued_q;
   logic [7:0]            cache_q [PLANES][PAGE_BYTES];
   logic [23:0]           die_cnt_q;
   logic [23:0]           arr_cnt_q;
   logic                  arr_cache_q;
   logic                  col_only_q;
   logic [PLANES-1:0]     fail_q, cfail_q;
   logic [PLANES-1:0]     arr_planes_q;
   logic                  st_val_q;

   // Decoded cycle types
   wire is_cmd  = bus.cyc_valid && bus.cyc_kind == mp_seq_pkg::CYC_CMD;
   wire is_addr = bus.cyc_valid && bus.cyc_kind == mp_seq_pkg::CYC_ADDR;
   wire is_data = bus.cyc_valid && bus.cyc_kind == mp_seq_pkg::CYC_DATA;
   wire [7:0] op = bus.cyc_byte;
   wire die_rdy = die_cnt_q == '0;
   wire arr_rdy = arr_cnt_q == '0;
   // Array flag drops whenever the die is busy, so only a cache run shows die 1, array 0
   wire arr_flag  = arr_rdy && die_rdy;
   wire is_status = is_cmd && (op == `OP_STATUS || op == `OP_STATUS_SEL);
   wire is_setup = op == `OP_PROG_SETUP || op == `OP_PROG_SETUP_ALT;
   // Plane select from the row: lowest block bit above the page bits, which are ignored
   wire [PB-1:0]     plane = PB'(addr_q[`PAGE_BITS +: PB]);
   wire [PLANES-1:0] sel   = PLANES'(1) << plane;

   // Sequencer
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st_q          <= S_IDLE;
         acnt_q        <= '0;
         addr_q        <= '0;
         col_q         <= '0;
         after_queue_q <= 1'b0;
         queued_q      <= '0;
         die_cnt_q     <= '0;
         arr_cnt_q     <= '0;
         arr_cache_q   <= 1'b0;
         col_only_q    <= 1'b0;
         fail_q        <= '0;
         cfail_q       <= '0;
         arr_planes_q  <= '0;
         st_val_q      <= 1'b0;
      end else begin
         st_val_q <= 1'b0;
         // Busy counters run down on their own; the reset opcode only returns to idle and empties the queue
         if (!die_rdy) die_cnt_q <= die_cnt_q - 24'h1;
         if (!arr_rdy) begin
            arr_cnt_q <= arr_cnt_q - 24'h1;
            if (arr_cnt_q == 24'h1) begin
               if (arr_cache_q) cfail_q <= FAIL_INJECT & arr_planes_q;
               else fail_q <= FAIL_INJECT & arr_planes_q;
               arr_cache_q <= 1'b0;
            end
         end
         if (is_cmd && op == `OP_RESET) begin
            st_q          <= S_IDLE;
            queued_q      <= '0;
            after_queue_q <= 1'b0;
         end else if (is_status) begin
            st_val_q <= 1'b1;
         end else if (is_cmd && die_rdy) begin
            case (1'b1)
               is_setup && st_q == S_IDLE: begin
                  // A plane queued by 11h keeps its cache data for the final confirm
                  if (!after_queue_q) begin
                     for (int p = 0; p < PLANES; p++) begin
                        for (int b = 0; b < PAGE_BYTES; b++) begin
                           cache_q[p][b] <= `ERASED_BYTE;
                        end
                     end
                  end
                  st_q       <= S_PADDR;
                  acnt_q     <= '0;
                  col_only_q <= 1'b0;
               end
               op == `OP_COL_CHANGE && st_q == S_PDATA: begin
                  st_q       <= S_PADDR;
                  acnt_q     <= '0;
                  col_only_q <= 1'b1;
               end
               op == `OP_PROG_QUEUE && st_q == S_PDATA: begin
                  queued_q      <= queued_q | sel;
                  after_queue_q <= 1'b1;
                  die_cnt_q     <= 24'(`QUEUE_BUSY_CYC);
                  st_q          <= S_IDLE;
               end
               op == `OP_PROG_FINAL && st_q == S_PDATA && arr_rdy: begin
                  arr_planes_q  <= queued_q | sel;
                  queued_q      <= '0;
                  arr_cnt_q     <= 24'(PROG_CYC);
                  die_cnt_q     <= 24'(PROG_CYC);
                  after_queue_q <= 1'b0;
                  fail_q        <= '0;
                  st_q          <= S_IDLE;
               end
               op == `OP_PROG_CACHE && st_q == S_PDATA && arr_rdy: begin
                  arr_planes_q  <= queued_q | sel;
                  queued_q      <= '0;
                  die_cnt_q     <= 24'(`CACHE_BUSY_CYC);
                  // Array write begins after the copy, so the array outlasts the die busy
                  arr_cnt_q     <= 24'(`CACHE_BUSY_CYC + PROG_CYC);
                  arr_cache_q   <= 1'b1;
                  after_queue_q <= 1'b0;
                  st_q          <= S_IDLE;
               end
               op == `OP_ERASE_SETUP && (st_q == S_IDLE || st_q == S_EWAIT)
                  && arr_rdy: begin
                  if (st_q == S_EWAIT) queued_q <= queued_q | sel;
                  st_q   <= S_EADDR;
                  acnt_q <= '0;
               end
               op == `OP_ERASE_QUEUE && st_q == S_EWAIT: begin
                  queued_q  <= queued_q | sel;
                  die_cnt_q <= 24'(`QUEUE_BUSY_CYC);
                  st_q      <= S_IDLE;
               end
               op == `OP_ERASE_FINAL && st_q == S_EWAIT: begin
                  arr_planes_q <= queued_q | sel;
                  queued_q     <= '0;
                  arr_cnt_q    <= 24'(ERASE_CYC);
                  die_cnt_q    <= 24'(ERASE_CYC);
                  fail_q       <= '0;
                  st_q         <= S_IDLE;
               end
               default: st_q <= st_q;
            endcase
         end else if (is_addr && st_q == S_PADDR) begin
            acnt_q <= acnt_q + 3'h1;
            // A column change rewrites the column only, so the plane row stays put
            if (!col_only_q) addr_q <= {addr_q[31:0], op};
            if (acnt_q == 3'h0) col_q <= CW'(op);
            if (acnt_q == 3'h1) col_q <= CW'({op, 8'(col_q)});
            if (acnt_q == (col_only_q ? `COL_ADDR_CYCLES : `PROG_ADDR_CYCLES) - 3'h1) begin
               st_q <= S_PDATA;
            end
         end else if (is_addr && st_q == S_EADDR) begin
            addr_q <= {addr_q[31:0], op};
            acnt_q <= acnt_q + 3'h1;
            if (acnt_q == `ERASE_ADDR_CYCLES - 3'h1) st_q <= S_EWAIT;
         end else if (is_data && st_q == S_PDATA) begin
            cache_q[plane][col_q] <= op;
            col_q <= col_q + CW'(1);
         end
      end
   end

   // Status outputs straight from flops
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_die_ready      <= 1'b1;
         o_array_ready    <= 1'b1;
         o_fail           <= '0;
         o_cache_fail     <= '0;
         bus.ready_busy_n <= 1'b1;
         bus.status_valid <= 1'b0;
         bus.status_byte  <= '0;
      end else begin
         o_die_ready      <= die_rdy;
         o_array_ready    <= arr_flag;
         o_fail           <= fail_q;
         o_cache_fail     <= cfail_q;
         bus.ready_busy_n <= die_rdy;
         bus.status_valid <= st_val_q;
         bus.status_byte  <= {1'b1, die_rdy, arr_flag, 3'h0, |cfail_q, |fail_q};
      end
   end
endmodule : mp_seq_die
`default_nettype wire

/* design/mp_seq_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mp_seq_regs.svh"
module mp_seq_ctrl (
   input  wire logic       i_clk,      // 100 MHz clock
   input  wire logic       i_reset,    // Synchronous reset
   input  wire logic [3:0] i_addr,     // Register address
   input  wire logic [7:0] i_wdata,    // Write data
   input  wire logic       i_wr,       // Write strobe
   input  wire logic       i_rd,       // Read strobe
   output logic      [7:0] o_rdata,    // Read data next cycle
   mp_seq_if.ctrl          bus         // Link to die
);
   logic [1:0] rb_sync_q;
   logic [7:0] status_q;
   // Host issues one bus cycle per write to REG_CMD, REG_ADDR or REG_FAIL
   wire wr_cmd  = i_wr && i_addr == `REG_CMD;
   wire wr_addr = i_wr && i_addr == `REG_ADDR;
   wire wr_data = i_wr && i_addr == `REG_FAIL;
   wire [7:0] rd_mux = i_addr == `REG_STATUS ? {7'h0, rb_sync_q[1]} :
                       i_addr == `REG_FAIL ? status_q : 8'h00;
   // Drive link and register answers
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         bus.cyc_valid <= 1'b0; bus.cyc_kind <= '0; bus.cyc_byte <= '0;
         rb_sync_q <= 2'b11; status_q <= '0; o_rdata <= '0;
      end else begin
         rb_sync_q <= {rb_sync_q[0], bus.ready_busy_n};
         bus.cyc_valid <= wr_cmd | wr_addr | wr_data;
         bus.cyc_kind <= wr_cmd ? mp_seq_pkg::CYC_CMD :
                         wr_addr ? mp_seq_pkg::CYC_ADDR : mp_seq_pkg::CYC_DATA;
         bus.cyc_byte <= i_wdata;
         if (bus.status_valid) status_q <= bus.status_byte;
         o_rdata <= i_rd ? rd_mux : 8'h00;
      end
   end
endmodule : mp_seq_ctrl
`default_nettype wire

/* verif/mp_seq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mp_seq_sva (
   input wire logic       i_clk,         // Clock
   input wire logic       i_reset,       // Sync reset
   input wire logic       cyc_valid,     // Link cycle
   input wire logic [1:0] cyc_kind,      // Cycle kind
   input wire logic [7:0] cyc_byte,      // Cycle payload
   input wire logic       ready_busy_n,  // Busy pin
   input wire logic       status_valid,  // Status pulse
   input wire logic [7:0] status_byte,   // Status byte
   input wire logic       o_die_ready,   // Die flag
   input wire logic       o_array_ready  // Array flag
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // ==================================================
   // Decode and busy length
   wire        cmd  = cyc_valid && cyc_kind == 2'h0;
   wire        idle = o_die_ready && o_array_ready;
   logic [7:0] low_q;
   // Saturates so a long program or erase busy cannot wrap into a short one
   always_ff @(posedge i_clk) begin
      low_q <= o_die_ready ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
   end
   // ==================================================
   // Checks
   chk_queue_busy: assert property (cmd && cyc_byte == 8'h11 && o_die_ready
      |-> ##[1:3] (!o_die_ready && !o_array_ready)[*8]) else $error("queue not busy");
   chk_erase_queue: assert property (cmd && cyc_byte == 8'hD1 && idle
      |-> ##[1:3] (!o_die_ready && !o_array_ready)[*8]) else $error("erase queue not busy");
   chk_flag_order: assert property (!o_die_ready |-> !o_array_ready)
      else $error("array ready while die busy");
   chk_erase_busy: assert property (cmd && cyc_byte == 8'hD0 && idle
      |-> ##[1:3] !o_die_ready && !o_array_ready) else $error("erase not busy");
   chk_prog_busy: assert property (cmd && cyc_byte == 8'h10 && idle
      |-> ##[1:3] (!o_array_ready)[*4]) else $error("program not busy");
   chk_busy_min: assert property ($rose(o_die_ready) |-> low_q >= 8'h12)
      else $error("busy too short");
   chk_pin_busy: assert property ((!o_die_ready)[*3] |-> !ready_busy_n)
      else $error("pin ready while busy");
   chk_pin_ready: assert property (o_die_ready[*3] |-> ready_busy_n)
      else $error("pin busy while ready");
   chk_status_answer: assert property (cmd && (cyc_byte == 8'h70 || cyc_byte == 8'h78)
      |-> ##2 status_valid) else $error("no status answer");
   chk_status_pulse: assert property (status_valid |-> status_byte[7] ##1 !status_valid)
      else $error("bad status pulse");
   cover property (cmd && cyc_byte == 8'h15);
   cover property (o_die_ready && !o_array_ready);
   cover property (cmd && cyc_byte == 8'hD1);
endmodule : mp_seq_sva
`default_nettype wire

/* verif/multiplane_program_erase_seq_test.sv */
`timescale 1ns/1ps
`default_nettype none
module multiplane_program_erase_seq_test;
   localparam logic [1:0] FAIL_INJ = 2'h2;  // Plane 1 always fails
   logic       i_clk = 1'b0;
   logic       i_reset = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr_s = 1'b0;
   logic       rd_s = 1'b0;
   logic [7:0] rdata, v, e;
   logic       die_rdy, arr_rdy;
   logic [1:0] fail, cfail;
   int         bad_count = 0, check_count = 0, cyc = 0, seed = 32'h225C81C2, pq[$];
   mp_seq_if link ();
   mp_seq_die #(.PROG_CYC(20), .ERASE_CYC(20), .FAIL_INJECT(FAIL_INJ)) mp_seq_die_i (
      .i_clk(i_clk), .i_reset(i_reset), .bus(link), .o_die_ready(die_rdy),
      .o_array_ready(arr_rdy), .o_fail(fail), .o_cache_fail(cfail));
   mp_seq_ctrl mp_seq_ctrl_i (.i_clk(i_clk), .i_reset(i_reset), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .bus(link));
   mp_seq_sva mp_seq_sva_i (.i_clk(i_clk), .i_reset(i_reset), .cyc_valid(link.cyc_valid),
      .cyc_kind(link.cyc_kind), .cyc_byte(link.cyc_byte), .ready_busy_n(link.ready_busy_n),
      .status_valid(link.status_valid), .status_byte(link.status_byte),
      .o_die_ready(die_rdy), .o_array_ready(arr_rdy));
   // ==================================================
   // Clock, hang guard and helpers
   always #5 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input logic [7:0] g, input logic [7:0] x);
      check_count++;
      if (g !== x) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, x);
      end
   endtask : cmp
   // Model: planes queued since the last final confirm
   function automatic logic [7:0] expf();
      logic [7:0] m = 8'h00;
      foreach (pq[k]) m[pq[k]] = FAIL_INJ[pq[k]];
      pq.delete();
      return m;
   endfunction : expf
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      addr  <= a;
      wdata <= d;
      wr_s  <= 1'b1;
      @(posedge i_clk);
      wr_s  <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge i_clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge i_clk);
      rd_s <= 1'b0;
      #1 v = rdata;
   endtask : rd
   // Address bytes all carry the plane, so any byte order lands it at row bit 8
   task automatic prog(input logic [7:0] opc, input logic [7:0] p, input logic [7:0] fin);
      pq.push_back(p);
      wr(4'h0, opc);
      repeat (5) wr(4'h1, p);
      repeat (3) wr(4'h3, 8'($random(seed)));
      wr(4'h0, 8'h85);
      repeat (2) wr(4'h1, 8'h00);
      wr(4'h3, 8'($random(seed)));
      wr(4'h0, fin);
   endtask : prog
   task automatic ers(input logic [7:0] p, input logic [7:0] fin);
      pq.push_back(p);
      wr(4'h0, 8'h60);
      repeat (3) wr(4'h1, p);
      if (fin !== 8'h00) wr(4'h0, fin);
   endtask : ers
   task automatic settle(input bit both);
      repeat (4) @(posedge i_clk);
      while (!(die_rdy === 1'b1 && (arr_rdy === 1'b1 || !both))) @(posedge i_clk);
      #1;
   endtask : settle
   task automatic stat(input logic [7:0] opc, input logic [7:0] x);
      wr(4'h0, opc);
      repeat (4) @(posedge i_clk);
      rd(4'h3);
      cmp(v & 8'hE1, x);
   endtask : stat
   // ==================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge i_clk);
      i_reset <= 1'b0;
      #1 cmp({2'h0, die_rdy, arr_rdy, fail, cfail}, 8'h30);
      rd(4'h2);
      cmp(v & 8'h01, 8'h01);
      rd(4'h5);
      prog(8'h80, 8'h00, 8'h11);
      wr(4'h0, 8'h80);
      settle(1'b1);
      prog(8'h81, 8'h01, 8'h10);
      settle(1'b1);
      cmp({6'h00, fail}, expf());
      stat(8'h78, 8'hE1);
      prog(8'h80, 8'h00, 8'h11);
      settle(1'b1);
      prog(8'h81, 8'h01, 8'h15);
      e = expf();
      settle(1'b0);
      cmp({6'h00, cfail}, 8'h00);
      cmp({6'h00, die_rdy, arr_rdy}, 8'h02);
      prog(8'h80, 8'h00, 8'h15);
      void'(expf());
      settle(1'b0);
      cmp({6'h00, cfail}, e);
      settle(1'b1);
      ers(8'h00, 8'hD1);
      settle(1'b1);
      ers(8'h01, 8'hD0);
      settle(1'b1);
      cmp({6'h00, fail}, expf());
      ers(8'h01, 8'h00);
      ers(8'h00, 8'hD0);
      settle(1'b1);
      cmp({6'h00, fail}, expf());
      ers(8'($random(seed) & 1), 8'hD0);
      settle(1'b1);
      e = expf();
      cmp({6'h00, fail}, e);
      stat(8'h70, {7'h70, |e});
      report_and_stop();
   end
endmodule : multiplane_program_erase_seq_test
`default_nettype wire
